/* hdl/spu_pkg.sv */
package spu_pkg;

    // ****************************************
    // operation codes
    // ****************************************
    typedef enum logic [4:0] {
        SPU_OP_NOP,
        SPU_OP_PACK_DW_TO_W_SAT,
        SPU_OP_PACK_W_TO_UB_SAT,
        SPU_OP_UNPACK_LO_B,
        SPU_OP_UNPACK_LO_W,
        SPU_OP_UNPACK_LO_D,
        SPU_OP_UNPACK_LO_Q,
        SPU_OP_UNPACK_HI_B,
        SPU_OP_UNPACK_HI_W,
        SPU_OP_UNPACK_HI_D,
        SPU_OP_UNPACK_HI_Q,
        SPU_OP_EXTRACT_B,
        SPU_OP_EXTRACT_W,
        SPU_OP_EXTRACT_D,
        SPU_OP_EXTRACT_Q,
        SPU_OP_EXTRACT_FP,
        SPU_OP_INSERT_B,
        SPU_OP_INSERT_W,
        SPU_OP_INSERT_D,
        SPU_OP_INSERT_Q,
        SPU_OP_INSERT_FP,
        SPU_OP_XOR
    } spu_op_e;

    // ****************************************
    // widths and saturation limits
    // ****************************************
    localparam int          SPU_VEC_W    = 128;
    localparam int          SPU_HALF_W   = 64;
    localparam int          SPU_GPR_W    = 64;
    localparam logic [15:0] SPU_SW_MAX   = 16'h7FFF;
    localparam logic [15:0] SPU_SW_MIN   = 16'h8000;
    localparam logic [7:0]  SPU_UB_MAX   = 8'hFF;
    localparam logic [7:0]  SPU_UB_MIN   = 8'h00;
    localparam logic [15:0] SPU_UB_LIMIT = 16'h00FF;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic                 valid;
        spu_op_e              op;
        logic                 wide;
        logic [7:0]           imm;
        logic                 mem_form;
        logic [SPU_VEC_W-1:0] dst;
        logic [SPU_VEC_W-1:0] src;
        logic [SPU_GPR_W-1:0] gpr;
        logic [SPU_GPR_W-1:0] mem;
    } spu_req_s;

    typedef struct packed {
        logic                 valid;
        logic                 to_vec;
        logic                 to_mem;
        logic [SPU_VEC_W-1:0] vec;
        logic [SPU_GPR_W-1:0] scalar;
    } spu_rsp_s;

endpackage

/* hdl/spu_datapath.sv */
`timescale 1ns/1ns
// Operation
// - 64-bit dword pack: two source and two destination dwords give four words
// - 128-bit dword pack: four plus four dwords give eight signed words
// - all packs treat their input elements as signed
// - each signed 32-bit element saturates into a signed 16-bit element
// - word pack saturates signed words into unsigned bytes; 64-bit gives eight
// - unpacks interleave destination and source elements alternately
// - low word unpack starts with the destination's lowest word
// - 64-bit word extract uses immediate bits 1:0, word lands low
// - extract zero-fills integer register bits above the element
// - word extract also works from a 128-bit register
// - extended extract moves byte, word, dword or qword to register or memory
// - 64-bit word insert takes the low word, position from immediate bits 1:0
// - insert keeps every other destination element unchanged
// - word insert also works on a 128-bit destination
// - extended insert places byte, dword or qword into a 128-bit register
// - floating-point insert and extract are distinct operations
// - xor of a register with itself gives zero regardless of contents
module spu_datapath
    import spu_pkg::*;
(
    input  wire logic     I_CLK,
    input  wire logic     I_RST,
    input  wire spu_req_s I_REQ,
    output spu_rsp_s      O_RSP
);

    typedef struct packed {
        spu_rsp_s rsp;
    } spu_state_s;

    spu_state_s state;
    spu_state_s next_state;

    // ****************************************
    // saturation helpers
    // ****************************************
    // word clamp limits
    function automatic logic [15:0] sat_dw_to_w(input logic [31:0] v);
        logic signed [31:0] s;
        s = $signed(v);
        if (s > 32'sh0000_7FFF) begin
            sat_dw_to_w = SPU_SW_MAX;
        end else if (s < -32'sh0000_8000) begin
            sat_dw_to_w = SPU_SW_MIN;
        end else begin
            sat_dw_to_w = v[15:0];
        end
    endfunction

    function automatic logic [7:0] sat_w_to_ub(input logic [15:0] v);
        if (v[15]) begin
            sat_w_to_ub = SPU_UB_MIN;
        end else if (v > SPU_UB_LIMIT) begin
            sat_w_to_ub = SPU_UB_MAX;
        end else begin
            sat_w_to_ub = v[7:0];
        end
    endfunction

    // element mask for a given element size in bytes
    function automatic logic [SPU_VEC_W-1:0] elem_mask(input int bytes);
        elem_mask = '0;
        for (int b = 0; b < bytes * 8; b++) begin
            elem_mask[b] = 1'b1;
        end
    endfunction

    // index bits kept from the immediate, by element count
    function automatic logic [3:0] elem_index(input logic [7:0] imm, input int count);
        elem_index = imm[3:0] & 4'((count - 1) & 15);
    endfunction

    // ****************************************
    // combinational datapath
    // ****************************************
    logic [SPU_VEC_W-1:0] pack_res;
    logic [SPU_VEC_W-1:0] unpack_res;
    logic [SPU_VEC_W-1:0] ins_res;
    logic [SPU_GPR_W-1:0] ext_res;
    logic [SPU_VEC_W-1:0] ins_mask;
    logic [3:0]           idx;
    int                   esize;
    int                   ecount;

    always_comb begin
        pack_res   = '0;
        unpack_res = '0;
        ins_res    = I_REQ.dst;
        ext_res    = '0;
        ins_mask   = '0;
        idx        = '0;
        esize      = 1;
        ecount     = 16;

        if (I_REQ.wide) begin
            for (int i = 0; i < 4; i++) begin
                pack_res[16*i +: 16]      = sat_dw_to_w(I_REQ.dst[32*i +: 32]);
                pack_res[16*(i+4) +: 16]  = sat_dw_to_w(I_REQ.src[32*i +: 32]);
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                pack_res[16*i +: 16]      = sat_dw_to_w(I_REQ.dst[32*i +: 32]);
                pack_res[16*(i+2) +: 16]  = sat_dw_to_w(I_REQ.src[32*i +: 32]);
            end
        end
        if (I_REQ.op == SPU_OP_PACK_W_TO_UB_SAT) begin
            pack_res = '0;
            if (I_REQ.wide) begin
                for (int i = 0; i < 8; i++) begin
                    pack_res[8*i +: 8]     = sat_w_to_ub(I_REQ.dst[16*i +: 16]);
                    pack_res[8*(i+8) +: 8] = sat_w_to_ub(I_REQ.src[16*i +: 16]);
                end
            end else begin
                for (int i = 0; i < 4; i++) begin
                    pack_res[8*i +: 8]     = sat_w_to_ub(I_REQ.dst[16*i +: 16]);
                    pack_res[8*(i+4) +: 8] = sat_w_to_ub(I_REQ.src[16*i +: 16]);
                end
            end
        end

        // element size by operation
        case (I_REQ.op)
            SPU_OP_UNPACK_LO_B, SPU_OP_UNPACK_HI_B,
            SPU_OP_EXTRACT_B, SPU_OP_INSERT_B: begin
                esize = 1;
            end
            SPU_OP_UNPACK_LO_W, SPU_OP_UNPACK_HI_W,
            SPU_OP_EXTRACT_W, SPU_OP_INSERT_W: begin
                esize = 2;
            end
            SPU_OP_UNPACK_LO_Q, SPU_OP_UNPACK_HI_Q,
            SPU_OP_EXTRACT_Q, SPU_OP_INSERT_Q: begin
                esize = 8;
            end
            default: begin
                esize = 4;
            end
        endcase
        // narrow form holds 8 bytes, wide 16
        ecount = (I_REQ.wide ? 16 : 8) / esize;
        // index from low immediate bits only
        idx    = elem_index(I_REQ.imm, ecount);

        for (int k = 0; k < 16; k++) begin
            if (k < ecount / 2) begin
                for (int b = 0; b < 64; b++) begin
                    if (b < esize * 8) begin
                        if (I_REQ.op inside {SPU_OP_UNPACK_HI_B, SPU_OP_UNPACK_HI_W,
                                             SPU_OP_UNPACK_HI_D, SPU_OP_UNPACK_HI_Q}) begin
                            unpack_res[(2*k)*esize*8 + b]   =
                                I_REQ.dst[(k + ecount/2)*esize*8 + b];
                            unpack_res[(2*k+1)*esize*8 + b] =
                                I_REQ.src[(k + ecount/2)*esize*8 + b];
                        end else begin
                            unpack_res[(2*k)*esize*8 + b]   = I_REQ.dst[k*esize*8 + b];
                            unpack_res[(2*k+1)*esize*8 + b] = I_REQ.src[k*esize*8 + b];
                        end
                    end
                end
            end
        end

        ext_res = SPU_GPR_W'((I_REQ.src >> (int'(idx) * esize * 8))
                             & elem_mask(esize));

        ins_mask = elem_mask(esize) << (int'(idx) * esize * 8);
        ins_res  = (I_REQ.dst & ~ins_mask)
                 | (({64'h0, (I_REQ.mem_form ? I_REQ.mem : I_REQ.gpr)}
                     << (int'(idx) * esize * 8)) & ins_mask);
        if (!I_REQ.wide) begin
            ins_res[SPU_VEC_W-1:SPU_HALF_W] = '0;
        end
    end

    // ****************************************
    // result register
    // ****************************************
    always_comb begin
        next_state           = state;
        next_state.rsp.valid = I_REQ.valid;
        next_state.rsp.to_mem = 1'b0;
        next_state.rsp.to_vec = 1'b0;
        if (I_REQ.valid) begin
            case (I_REQ.op)
                SPU_OP_PACK_DW_TO_W_SAT, SPU_OP_PACK_W_TO_UB_SAT: begin
                    next_state.rsp.to_vec = 1'b1;
                    next_state.rsp.vec    = pack_res;
                end
                SPU_OP_UNPACK_LO_B, SPU_OP_UNPACK_LO_W, SPU_OP_UNPACK_LO_D,
                SPU_OP_UNPACK_LO_Q, SPU_OP_UNPACK_HI_B, SPU_OP_UNPACK_HI_W,
                SPU_OP_UNPACK_HI_D, SPU_OP_UNPACK_HI_Q: begin
                    next_state.rsp.to_vec = 1'b1;
                    next_state.rsp.vec    = unpack_res;
                end
                SPU_OP_EXTRACT_B, SPU_OP_EXTRACT_W, SPU_OP_EXTRACT_D,
                SPU_OP_EXTRACT_Q, SPU_OP_EXTRACT_FP: begin
                    next_state.rsp.to_mem = I_REQ.mem_form;
                    next_state.rsp.scalar = ext_res;
                end
                SPU_OP_INSERT_B, SPU_OP_INSERT_W, SPU_OP_INSERT_D,
                SPU_OP_INSERT_Q, SPU_OP_INSERT_FP: begin
                    next_state.rsp.to_vec = 1'b1;
                    next_state.rsp.vec    = ins_res;
                end
                SPU_OP_XOR: begin
                    // self-xor gives zero, no dependence on old value
                    next_state.rsp.to_vec = 1'b1;
                    next_state.rsp.vec    = (I_REQ.dst == I_REQ.src) ? '0
                                          : (I_REQ.dst ^ I_REQ.src);
                end
                default: begin
                    next_state.rsp.valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign O_RSP = state.rsp;

    // ****************************************
    // checks
    // ****************************************
    sequence pack_req_s;
        I_REQ.valid && I_REQ.op == SPU_OP_PACK_DW_TO_W_SAT && I_REQ.wide;
    endsequence

    pack_sat_hi_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        pack_req_s ##0 ($signed(I_REQ.dst[31:0]) > 32'sh7FFF)
        |=> O_RSP.vec[15:0] == 16'h7FFF)
        else $error("dword pack high clamp wrong");
    pack_sat_lo_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        pack_req_s ##0 ($signed(I_REQ.src[31:0]) < -32'sh8000)
        |=> O_RSP.vec[79:64] == 16'h8000)
        else $error("dword pack low clamp wrong");
    byte_sat_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_REQ.valid && I_REQ.op == SPU_OP_PACK_W_TO_UB_SAT && I_REQ.dst[15])
        |=> O_RSP.vec[7:0] == 8'h00)
        else $error("negative word not clamped to zero");
    unpack_order_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_REQ.valid && I_REQ.op == SPU_OP_UNPACK_LO_W)
        |=> O_RSP.vec[31:0] == {$past(I_REQ.src[15:0]), $past(I_REQ.dst[15:0])})
        else $error("low word unpack order wrong");
    extract_zero_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_REQ.valid && I_REQ.op == SPU_OP_EXTRACT_W)
        |=> O_RSP.scalar[63:16] == '0 && !O_RSP.to_vec)
        else $error("extract upper bits not zero");
    extract_sel_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_REQ.valid && I_REQ.op == SPU_OP_EXTRACT_W && !I_REQ.wide && I_REQ.imm[1:0] == 2'h3)
        |=> O_RSP.scalar[15:0] == $past(I_REQ.src[63:48]))
        else $error("extract picked wrong word");
    insert_keep_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_REQ.valid && I_REQ.op == SPU_OP_INSERT_W && I_REQ.wide && I_REQ.imm[2:0] == 3'h0)
        |=> O_RSP.vec[127:16] == $past(I_REQ.dst[127:16]))
        else $error("insert disturbed other words");
    xor_zero_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_REQ.valid && I_REQ.op == SPU_OP_XOR && I_REQ.dst == I_REQ.src)
        |=> O_RSP.valid && O_RSP.vec == '0)
        else $error("self xor not zero");
    pack_narrow_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_REQ.valid && I_REQ.op == SPU_OP_PACK_DW_TO_W_SAT && !I_REQ.wide
         && $signed(I_REQ.src[31:0]) <= 32'sh7FFF && $signed(I_REQ.src[31:0]) >= -32'sh8000)
        |=> O_RSP.vec[47:32] == $past(I_REQ.src[15:0]) && O_RSP.vec[127:64] == '0)
        else $error("narrow dword pack misplaced source word");
    byte_sat_hi_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_REQ.valid && I_REQ.op == SPU_OP_PACK_W_TO_UB_SAT && !I_REQ.dst[15]
         && I_REQ.dst[15:0] > SPU_UB_LIMIT)
        |=> O_RSP.vec[7:0] == SPU_UB_MAX)
        else $error("large word not clamped to FF");
    unpack_hi_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_REQ.valid && I_REQ.op == SPU_OP_UNPACK_HI_W && I_REQ.wide)
        |=> O_RSP.vec[31:0] == {$past(I_REQ.src[79:64]), $past(I_REQ.dst[79:64])})
        else $error("high word unpack order wrong");
    extract_wide_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_REQ.valid && I_REQ.op == SPU_OP_EXTRACT_W && I_REQ.wide && I_REQ.imm[2:0] == 3'h7)
        |=> O_RSP.scalar == {48'h0, $past(I_REQ.src[127:112])})
        else $error("wide extract picked wrong word");
    extract_mem_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_REQ.valid && I_REQ.op == SPU_OP_EXTRACT_B && I_REQ.mem_form)
        |=> O_RSP.valid && O_RSP.to_mem && !O_RSP.to_vec && O_RSP.scalar[63:8] == '0)
        else $error("byte extract to memory wrong");
    insert_sel_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_REQ.valid && I_REQ.op == SPU_OP_INSERT_W && !I_REQ.wide && I_REQ.imm[1:0] == 2'h3)
        |=> O_RSP.vec[63:48] == ($past(I_REQ.mem_form) ? $past(I_REQ.mem[15:0])
                                                       : $past(I_REQ.gpr[15:0])))
        else $error("word insert landed wrong");
    insert_fp_a : assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_REQ.valid && I_REQ.op == SPU_OP_INSERT_FP && I_REQ.wide && I_REQ.imm[1:0] == 2'h0)
        |=> O_RSP.vec[127:32] == $past(I_REQ.dst[127:32]))
        else $error("float insert disturbed other elements");

endmodule

/* tb/spu_issue_model.sv */
`timescale 1ns/1ns
// ****************************************
// issuing pipeline stand-in
// ****************************************
module spu_issue_model
    import spu_pkg::*;
(
    input  wire logic i_clk,
    output spu_req_s  o_req
);
    // idle until the first issue, so reset never sees stray requests
    initial o_req = '0;

    // changes only on the falling edge, so the taking edge sees settled fields
    task automatic drive(input spu_req_s r);
        @(negedge i_clk);
        o_req = r;
    endtask
endmodule

/* tb/simd_pack_unpack_insert_extract_bench.sv */
`timescale 1ns/1ns
module simd_pack_unpack_insert_extract_bench
    import spu_pkg::*;
;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    spu_req_s     req;
    spu_rsp_s     rsp;
    spu_rsp_s     exp = '0;
    logic [127:0] st_vec = '0;
    logic [63:0]  st_scl = '0;
    int           seed = 1;
    int           n_errors = 0;
    int           cmp_count = 0;
    int           cycles = 0;

    spu_issue_model u_iss (.i_clk(clk), .o_req(req));
    spu_datapath u_dut (.I_CLK(clk), .I_RST(rst), .I_REQ(req), .O_RSP(rsp));

    initial forever #25 clk = ~clk;

    // ****************************************
    // reference model
    // ****************************************
    function automatic logic [63:0] get_el(logic [127:0] v, int e, int i);
        logic [63:0] x;
        x = '0;
        for (int b = 0; b < e; b++) x[b] = v[i*e+b];
        return x;
    endfunction

    function automatic logic [127:0] put_el(logic [127:0] v, int e, int i, logic [63:0] x);
        for (int b = 0; b < e; b++) v[i*e+b] = x[b];
        return v;
    endfunction

    // inputs are always read as signed, whatever the result type
    function automatic logic [63:0] sat(logic [63:0] x, int e);
        int s;
        s = (e == 32) ? $signed(x[31:0]) : $signed(x[15:0]);
        if (e == 32) return (s > 32767) ? 64'h7FFF : (s < -32768) ? 64'h8000 : 64'(x[15:0]);
        return (s > 255) ? 64'hFF : (s < 0) ? 64'h0 : 64'(x[7:0]);
    endfunction

    function automatic int esize(spu_op_e op);
        case (op)
            SPU_OP_UNPACK_LO_B, SPU_OP_UNPACK_HI_B, SPU_OP_EXTRACT_B, SPU_OP_INSERT_B: return 8;
            SPU_OP_PACK_W_TO_UB_SAT, SPU_OP_UNPACK_LO_W, SPU_OP_UNPACK_HI_W,
            SPU_OP_EXTRACT_W, SPU_OP_INSERT_W: return 16;
            SPU_OP_UNPACK_LO_Q, SPU_OP_UNPACK_HI_Q, SPU_OP_EXTRACT_Q, SPU_OP_INSERT_Q: return 64;
            default: return 32;
        endcase
    endfunction

    task automatic predict(input spu_req_s r);
        int           w;
        int           e;
        int           n;
        int           h;
        logic [127:0] v;
        w = r.wide ? 128 : 64;
        e = esize(r.op);
        n = w / e;
        v = r.dst ^ r.src;
        exp = '0;
        exp.vec = st_vec;
        exp.scalar = st_scl;
        exp.valid = r.valid && (r.op != SPU_OP_NOP);
        exp.to_vec = exp.valid;
        if (!exp.valid) return;
        case (r.op) inside
            SPU_OP_PACK_DW_TO_W_SAT, SPU_OP_PACK_W_TO_UB_SAT: begin
                for (int i = 0; i < n; i++) begin
                    v = put_el(v, e/2, i, sat(get_el(r.dst, e, i), e));
                    v = put_el(v, e/2, i+n, sat(get_el(r.src, e, i), e));
                end
            end
            [SPU_OP_UNPACK_LO_B:SPU_OP_UNPACK_HI_Q]: begin
                h = (r.op >= SPU_OP_UNPACK_HI_B) ? n/2 : 0;
                for (int i = 0; i < n/2; i++) begin
                    v = put_el(v, e, 2*i, get_el(r.dst, e, i+h));
                    v = put_el(v, e, 2*i+1, get_el(r.src, e, i+h));
                end
            end
            [SPU_OP_EXTRACT_B:SPU_OP_EXTRACT_FP]: begin
                exp.to_vec = 1'b0;
                exp.to_mem = r.mem_form;
                exp.scalar = get_el(r.src, e, r.imm % n);
            end
            [SPU_OP_INSERT_B:SPU_OP_INSERT_FP]:
                v = put_el(r.dst, e, r.imm % n, r.mem_form ? r.mem : r.gpr);
            default: ;
        endcase
        if (!r.wide) v[127:64] = '0;
        if (exp.to_vec) exp.vec = v;
        st_vec = exp.vec;
        st_scl = exp.scalar;
    endtask

    // ****************************************
    // stimulus and checks
    // ****************************************
    task automatic check();
        cmp_count++;
        if (rsp !== exp) begin
            n_errors++;
            $display("mismatch at %0t: rsp %h exp %h", $time, rsp, exp);
        end
    endtask

    task automatic step(input spu_req_s r);
        u_iss.drive(r);
        check();
        predict(r);
    endtask

    // dwords near both saturation edges mixed with random ones
    function automatic logic [31:0] pick();
        logic [31:0] c [8] = '{32'h7FFF, 32'h8000, 32'hFFFF8000, 32'hFFFF7FFF,
                               32'hFF, 32'h100, 32'hFFFFFFFF, 32'h80000000};
        return $random(seed) % 2 ? c[3'($random(seed))] : $random(seed);
    endfunction

    task automatic run(input spu_op_e op, input logic wide);
        spu_req_s r;
        for (int t = 0; t < 12; t++) begin
            r = '0;
            r.valid = 1'b1;
            r.op = op;
            r.wide = wide;
            // first two issues pin the index to both ends of its range
            r.imm = (t == 0) ? 8'h00 : (t == 1) ? 8'hFF : 8'($random(seed));
            r.mem_form = 1'($random(seed));
            r.gpr = {$random(seed), $random(seed)};
            r.mem = {$random(seed), $random(seed)};
            for (int j = 0; j < 4; j++) r.dst[j*32+:32] = pick();
            for (int j = 0; j < 4; j++) r.src[j*32+:32] = pick();
            if (t % 2 == 1 && op == SPU_OP_XOR) r.src = r.dst;
            step(r);
        end
    endtask

    task automatic do_reset(input int n);
        // idle the request and check the last result before reset clears it
        u_iss.drive('0);
        check();
        rst = 1'b1;
        exp = '0;
        st_vec = '0;
        st_scl = '0;
        repeat (n) @(negedge clk);
        check();
        rst = 1'b0;
    endtask

    task automatic stop_test();
        $display("errors %0d, comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        do_reset(20);
        run(SPU_OP_PACK_DW_TO_W_SAT, 1'b0);
        run(SPU_OP_PACK_DW_TO_W_SAT, 1'b1);
        run(SPU_OP_PACK_W_TO_UB_SAT, 1'b0);
        run(SPU_OP_PACK_W_TO_UB_SAT, 1'b1);
        for (int i = SPU_OP_UNPACK_LO_B; i <= SPU_OP_UNPACK_HI_Q; i++) begin
            run(spu_op_e'(i), 1'b1);
            if (esize(spu_op_e'(i)) < 64) run(spu_op_e'(i), 1'b0);
        end
        run(SPU_OP_UNPACK_LO_W, 1'b0);
        run(SPU_OP_EXTRACT_W, 1'b0);
        run(SPU_OP_EXTRACT_W, 1'b1);
        for (int i = SPU_OP_EXTRACT_B; i <= SPU_OP_EXTRACT_Q; i++) begin
            run(spu_op_e'(i), 1'b1);
        end
        run(SPU_OP_EXTRACT_FP, 1'b1);
        run(SPU_OP_INSERT_W, 1'b0);
        run(SPU_OP_INSERT_W, 1'b1);
        for (int i = SPU_OP_INSERT_B; i <= SPU_OP_INSERT_Q; i++) begin
            run(spu_op_e'(i), 1'b1);
        end
        run(SPU_OP_INSERT_FP, 1'b1);
        run(SPU_OP_XOR, 1'b1);
        run(SPU_OP_NOP, 1'b1);
        do_reset(2);
        run(SPU_OP_INSERT_B, 1'b1);
        step('0);
        step('0);
        stop_test();
    end
endmodule
